// ===== acr_params.svh
// constants for the record-path configuration registers
// Functional notes
// - left converter input follows bits 13:12
// - right converter input follows bits 11:10
// - mic preamp gain 0/0/6/12 dB
// - master clock ratio 256/384/512/256 Fs
// - rate code 0..8 tells PLL sample rate
// - word format follows bits 1:0, MSB first
// - left gain 7Fh +20, 57h 0, 07h -40
// - left gain codes below 07h mean mute
// - gain changes always soft-stepped
// - left mute ramps down, keeps gain, resets set
// - muted input tied to common mode voltage
// - right mute bit 7 ramps likewise, resets set
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// register addresses
`define ACR_ADDR_W          6
`define ACR_ADDR_PATH       6'h00
`define ACR_ADDR_GAIN       6'h01
`define ACR_ADDR_STATUS     6'h04

// reset values
`define ACR_PATH_RESET      16'hc003
`define ACR_GAIN_RESET      16'hd7d7

// path control fields
`define ACR_LSEL_HI         13
`define ACR_LSEL_LO         12
`define ACR_RSEL_HI         11
`define ACR_RSEL_LO         10
`define ACR_MIC_HI          9
`define ACR_MIC_LO          8
`define ACR_MCLK_HI         7
`define ACR_MCLK_LO         6
`define ACR_RATE_HI         5
`define ACR_RATE_LO         2
`define ACR_FMT_HI          1
`define ACR_FMT_LO          0
`define ACR_RATE_MAX        4'h8

// gain control fields
`define ACR_LMUTE_BIT       15
`define ACR_LGAIN_HI        14
`define ACR_LGAIN_LO        8
`define ACR_RMUTE_BIT       7
`define ACR_RGAIN_HI        6
`define ACR_RGAIN_LO        0
`define ACR_GAIN_MIN        7'h07
`define ACR_GAIN_UNITY      7'h57
`define ACR_GAIN_MAX        7'h7f

// soft-step timing
`define ACR_CLK_PERIOD_NS   10
`define ACR_STEP_NS         20000
`define ACR_STEP_CYCLES     (`ACR_STEP_NS / `ACR_CLK_PERIOD_NS)
`define ACR_STEP_CNT_W      11

`endif

// ===== acr_pkg.sv
// types for the record-path configuration registers
`default_nettype none
package acr_pkg;
	typedef enum logic [1:0] {MIC_GAIN_0DB, MIC_GAIN_6DB, MIC_GAIN_12DB} acr_mic_e;
	typedef enum logic [1:0] {MCLK_256FS, MCLK_384FS, MCLK_512FS} acr_mclk_e;
	typedef enum logic [1:0] {JUST_RIGHT, JUST_LEFT, JUST_I2S} acr_just_e;

	typedef struct packed {
		logic [6:0] applied;
		logic       hardMute;
	} acr_ramp_s;

	typedef struct packed {
		logic [15:0] pathCtl;
		logic [15:0] gainCtl;
		logic [10:0] stepCnt;
		logic        stepTick;
		logic [15:0] rdData;
		logic        rdValid;
	} acr_regs_s;
endpackage
`default_nettype wire

// ===== acr_ramp_if.sv
// link between register bank and one gain soft-stepper
`timescale 1ns/1ps
`default_nettype none
interface acr_ramp_if;
	logic       stepTick;
	logic       muteBit;
	logic [6:0] gainCode;
	logic [6:0] appliedGain;
	logic       hardMute;
	logic       ramping;

	modport ctrl (output stepTick, muteBit, gainCode, input appliedGain, hardMute, ramping);
	modport ramp (input stepTick, muteBit, gainCode, output appliedGain, hardMute, ramping);
endinterface
`default_nettype wire

// ===== acr_gain_ramp.sv
// soft-stepping gain stage with hard mute for one record channel
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"
module acr_gain_ramp
	import acr_pkg::*;
(
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// control from register bank
	acr_ramp_if.ramp   rif
);
	acr_ramp_s st_r;
	acr_ramp_s st_nxt;
	logic      muteReq;
	logic [6:0] goal;

	// codes below the floor also mean mute
	assign muteReq = rif.muteBit || (rif.gainCode < `ACR_GAIN_MIN);
	assign goal    = muteReq ? `ACR_GAIN_MIN : rif.gainCode;

	// one code per tick, mute only at the floor
	always_comb begin
		st_nxt = st_r;
		if (rif.stepTick) begin
			if (muteReq) begin
				if (st_r.applied > `ACR_GAIN_MIN)
					st_nxt.applied = st_r.applied - 7'h01;
				else
					st_nxt.hardMute = 1'b1;
			end else if (st_r.hardMute) begin
				st_nxt.hardMute = 1'b0; // unmute first, then climb
			end else if (st_r.applied < goal) begin
				st_nxt.applied = st_r.applied + 7'h01;
			end else if (st_r.applied > goal) begin
				st_nxt.applied = st_r.applied - 7'h01;
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= '{applied: `ACR_GAIN_MIN, hardMute: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rif.appliedGain = st_r.applied;
	assign rif.hardMute    = st_r.hardMute;
	assign rif.ramping     = (st_r.applied != goal) || (st_r.hardMute != muteReq);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_step_on_tick;
		!rif.stepTick |=> $stable(rif.appliedGain) && $stable(rif.hardMute);
	endproperty
	a_step_on_tick: assert property (p_step_on_tick) else $error("gain moved without tick");

	property p_one_code;
		rif.stepTick |=> (rif.appliedGain == $past(rif.appliedGain) + 7'h01)
			|| (rif.appliedGain == $past(rif.appliedGain) - 7'h01)
			|| (rif.appliedGain == $past(rif.appliedGain));
	endproperty
	a_one_code: assert property (p_one_code) else $error("gain jumped more than one code");

	property p_mute_at_floor;
		$rose(rif.hardMute) |-> rif.appliedGain == `ACR_GAIN_MIN;
	endproperty
	a_mute_at_floor: assert property (p_mute_at_floor) else $error("muted above floor");

	property p_no_climb_muted;
		rif.hardMute |-> rif.appliedGain == `ACR_GAIN_MIN;
	endproperty
	a_no_climb_muted: assert property (p_no_climb_muted) else $error("gain above floor while muted");

	property p_low_code_mutes;
		rif.stepTick && rif.gainCode < `ACR_GAIN_MIN && rif.appliedGain == `ACR_GAIN_MIN
			|=> rif.hardMute;
	endproperty
	a_low_code_mutes: assert property (p_low_code_mutes) else $error("low code did not mute");

	c_mute_reached: cover property ($rose(rif.hardMute));
	c_unmuted: cover property ($fell(rif.hardMute));
endmodule // acr_gain_ramp
`default_nettype wire

// ===== acr_record_regs.sv
// record-path control and gain registers with soft-stepped gain
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"
module acr_record_regs
	import acr_pkg::*;
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// register port from serial control decoder
	input  wire logic                    regWrite,
	input  wire logic                    regRead,
	input  wire logic [`ACR_ADDR_W-1:0]  regAddr,
	input  wire logic [15:0]             regWdata,
	output logic      [15:0]             regRdata,
	output logic                         regRdValid,
	// converter input routing
	output logic      [1:0]              leftInputSelect,
	output logic      [1:0]              rightInputSelect,
	output var acr_mic_e                 micPreampGain,
	// clocking and rate
	output var acr_mclk_e                mclkRatio,
	output logic      [3:0]              sampleRateCode,
	output logic                         sampleRateValid,
	// serial audio word format
	output logic                         wordLen20,
	output var acr_just_e                dacJustify,
	output var acr_just_e                adcJustify,
	// applied gain and mute per converter
	output logic      [6:0]              leftRecordGain,
	output logic                         leftTieCommonMode,
	output logic                         leftRamping,
	output logic      [6:0]              rightRecordGain,
	output logic                         rightTieCommonMode,
	output logic                         rightRamping
);
	acr_regs_s st_r;
	acr_regs_s st_nxt;
	logic [1:0] fmtCode;
	logic [15:0] statusWord;

	acr_ramp_if rampIf [2] ();

	// step interval divider and register writes
	always_comb begin
		st_nxt          = st_r;
		st_nxt.rdValid  = regRead;
		st_nxt.stepTick = 1'b0;
		if (st_r.stepCnt == `ACR_STEP_CNT_W'(`ACR_STEP_CYCLES - 1)) begin
			st_nxt.stepCnt  = '0;
			st_nxt.stepTick = 1'b1;
		end else begin
			st_nxt.stepCnt = st_r.stepCnt + `ACR_STEP_CNT_W'(1);
		end
		if (regWrite) begin
			case (regAddr)
				`ACR_ADDR_PATH: st_nxt.pathCtl = regWdata;
				`ACR_ADDR_GAIN: st_nxt.gainCtl = regWdata;
				default: ;
			endcase
		end
		if (regRead) begin
			case (regAddr)
				`ACR_ADDR_PATH:   st_nxt.rdData = st_r.pathCtl;
				`ACR_ADDR_GAIN:   st_nxt.rdData = st_r.gainCtl;
				`ACR_ADDR_STATUS: st_nxt.rdData = statusWord;
				default:          st_nxt.rdData = 16'h0000;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= '{pathCtl: `ACR_PATH_RESET, gainCtl: `ACR_GAIN_RESET,
				stepCnt: '0, stepTick: 1'b0, rdData: 16'h0000, rdValid: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign regRdata   = st_r.rdData;
	assign regRdValid = st_r.rdValid;

	// live state seen by software
	assign statusWord = {leftTieCommonMode, leftRecordGain, rightTieCommonMode, rightRecordGain};

	// input routing fields
	assign leftInputSelect  = st_r.pathCtl[`ACR_LSEL_HI:`ACR_LSEL_LO];
	assign rightInputSelect = st_r.pathCtl[`ACR_RSEL_HI:`ACR_RSEL_LO];

	// mic preamp decode, codes 0 and 1 both 0 dB
	always_comb begin
		case (st_r.pathCtl[`ACR_MIC_HI:`ACR_MIC_LO])
			2'h2:    micPreampGain = MIC_GAIN_6DB;
			2'h3:    micPreampGain = MIC_GAIN_12DB;
			default: micPreampGain = MIC_GAIN_0DB;
		endcase
	end

	// master clock ratio, code 3 aliases 256 Fs
	always_comb begin
		case (st_r.pathCtl[`ACR_MCLK_HI:`ACR_MCLK_LO])
			2'h1:    mclkRatio = MCLK_384FS;
			2'h2:    mclkRatio = MCLK_512FS;
			default: mclkRatio = MCLK_256FS;
		endcase
	end

	// rate code passed to the PLL, invalid codes flagged
	assign sampleRateCode  = st_r.pathCtl[`ACR_RATE_HI:`ACR_RATE_LO];
	assign sampleRateValid = (sampleRateCode <= `ACR_RATE_MAX);

	// word length and justification
	assign fmtCode = st_r.pathCtl[`ACR_FMT_HI:`ACR_FMT_LO];
	always_comb begin
		wordLen20 = (fmtCode != 2'h0);
		case (fmtCode)
			2'h0, 2'h1: begin
				dacJustify = JUST_RIGHT;
				adcJustify = JUST_LEFT;
			end
			2'h2: begin
				dacJustify = JUST_LEFT;
				adcJustify = JUST_LEFT;
			end
			default: begin
				dacJustify = JUST_I2S;
				adcJustify = JUST_I2S;
			end
		endcase
	end

	// one soft-stepper per converter
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			assign rampIf[ch].stepTick = st_r.stepTick;
			if (ch == 0) begin : g_left
				assign rampIf[ch].muteBit  = st_r.gainCtl[`ACR_LMUTE_BIT];
				assign rampIf[ch].gainCode = st_r.gainCtl[`ACR_LGAIN_HI:`ACR_LGAIN_LO];
			end else begin : g_right
				assign rampIf[ch].muteBit  = st_r.gainCtl[`ACR_RMUTE_BIT];
				assign rampIf[ch].gainCode = st_r.gainCtl[`ACR_RGAIN_HI:`ACR_RGAIN_LO];
			end
			acr_gain_ramp u_ramp (
				.clk   (clk),
				.rst_n (rst_n),
				.rif   (rampIf[ch])
			);
		end
	endgenerate

	assign leftRecordGain     = rampIf[0].appliedGain;
	assign leftTieCommonMode  = rampIf[0].hardMute;
	assign leftRamping        = rampIf[0].ramping;
	assign rightRecordGain    = rampIf[1].appliedGain;
	assign rightTieCommonMode = rampIf[1].hardMute;
	assign rightRamping       = rampIf[1].ramping;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// field decodes follow the written word
	property p_left_sel;
		regWrite && regAddr == `ACR_ADDR_PATH |=> leftInputSelect == $past(regWdata[13:12]);
	endproperty
	a_left_sel: assert property (p_left_sel) else $error("left select not taken");

	property p_right_sel;
		regWrite && regAddr == `ACR_ADDR_PATH |=> rightInputSelect == $past(regWdata[11:10]);
	endproperty
	a_right_sel: assert property (p_right_sel) else $error("right select not taken");

	property p_mic_gain;
		regWrite && regAddr == `ACR_ADDR_PATH |=> micPreampGain == ($past(regWdata[9]) ?
			($past(regWdata[8]) ? MIC_GAIN_12DB : MIC_GAIN_6DB) : MIC_GAIN_0DB);
	endproperty
	a_mic_gain: assert property (p_mic_gain) else $error("mic gain decode wrong");

	property p_mclk;
		st_r.pathCtl[7:6] == 2'h3 || st_r.pathCtl[7:6] == 2'h0 |-> mclkRatio == MCLK_256FS;
	endproperty
	a_mclk: assert property (p_mclk) else $error("master clock ratio wrong");

	property p_rate;
		regWrite && regAddr == `ACR_ADDR_PATH |=> sampleRateCode == $past(regWdata[5:2])
			&& sampleRateValid == ($past(regWdata[5:2]) <= 4'h8);
	endproperty
	a_rate: assert property (p_rate) else $error("rate code or validity wrong");

	property p_format;
		fmtCode == 2'h3 |-> wordLen20 && dacJustify == JUST_I2S && adcJustify == JUST_I2S;
	endproperty
	a_format: assert property (p_format) else $error("default format wrong");

	property p_gain_taken;
		regWrite && regAddr == `ACR_ADDR_GAIN |=> rampIf[0].gainCode == $past(regWdata[14:8])
			&& rampIf[0].muteBit == $past(regWdata[15]);
	endproperty
	a_gain_taken: assert property (p_gain_taken) else $error("left gain not stored");

	property p_tick_period;
		st_r.stepTick |=> !st_r.stepTick [*8];
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("step ticks too close");

	// step divider wraps once per interval
	property p_tick_wrap;
		st_r.stepCnt == `ACR_STEP_CNT_W'(`ACR_STEP_CYCLES - 1)
			|=> st_r.stepTick && st_r.stepCnt == '0;
	endproperty
	a_tick_wrap: assert property (p_tick_wrap) else $error("step divider did not wrap");

	property p_count_up;
		st_r.stepCnt != `ACR_STEP_CNT_W'(`ACR_STEP_CYCLES - 1)
			|=> !st_r.stepTick && st_r.stepCnt == $past(st_r.stepCnt) + `ACR_STEP_CNT_W'(1);
	endproperty
	a_count_up: assert property (p_count_up) else $error("step divider skipped");

	property p_tick_at_zero;
		st_r.stepTick |-> st_r.stepCnt == '0;
	endproperty
	a_tick_at_zero: assert property (p_tick_at_zero) else $error("tick off the wrap");

	// read port answers one cycle after the strobe
	property p_rd_valid;
		regRead |=> regRdValid;
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read not answered");

	property p_rd_idle;
		!regRead |=> !regRdValid;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("valid without read");

	property p_rd_hold;
		!regRead |=> $stable(regRdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved between reads");

	property p_rd_path;
		regRead && regAddr == `ACR_ADDR_PATH |=> regRdata == $past(st_r.pathCtl);
	endproperty
	a_rd_path: assert property (p_rd_path) else $error("path word read wrong");

	property p_rd_gain;
		regRead && regAddr == `ACR_ADDR_GAIN |=> regRdata == $past(st_r.gainCtl);
	endproperty
	a_rd_gain: assert property (p_rd_gain) else $error("gain word read wrong");

	property p_rd_unmapped;
		regRead && regAddr != `ACR_ADDR_PATH && regAddr != `ACR_ADDR_GAIN
			&& regAddr != `ACR_ADDR_STATUS |=> regRdata == 16'h0000;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

	// stored words change only on their own writes
	property p_status_wr;
		regWrite && regAddr == `ACR_ADDR_STATUS
			|=> $stable(st_r.pathCtl) && $stable(st_r.gainCtl);
	endproperty
	a_status_wr: assert property (p_status_wr) else $error("status write took effect");

	property p_no_wr_hold;
		!regWrite |=> $stable(st_r.pathCtl) && $stable(st_r.gainCtl);
	endproperty
	a_no_wr_hold: assert property (p_no_wr_hold) else $error("register moved without write");

	property p_right_gain_taken;
		regWrite && regAddr == `ACR_ADDR_GAIN |=> rampIf[1].gainCode == $past(regWdata[6:0])
			&& rampIf[1].muteBit == $past(regWdata[7]);
	endproperty
	a_right_gain_taken: assert property (p_right_gain_taken) else $error("right gain not stored");

	// remaining clock ratio and format codes
	property p_mclk_384;
		st_r.pathCtl[7:6] == 2'h1 |-> mclkRatio == MCLK_384FS;
	endproperty
	a_mclk_384: assert property (p_mclk_384) else $error("384 ratio wrong");

	property p_mclk_512;
		st_r.pathCtl[7:6] == 2'h2 |-> mclkRatio == MCLK_512FS;
	endproperty
	a_mclk_512: assert property (p_mclk_512) else $error("512 ratio wrong");

	property p_fmt_16;
		fmtCode == 2'h0
			|-> !wordLen20 && dacJustify == JUST_RIGHT && adcJustify == JUST_LEFT;
	endproperty
	a_fmt_16: assert property (p_fmt_16) else $error("16-bit format wrong");

	property p_fmt_20r;
		fmtCode == 2'h1
			|-> wordLen20 && dacJustify == JUST_RIGHT && adcJustify == JUST_LEFT;
	endproperty
	a_fmt_20r: assert property (p_fmt_20r) else $error("20-bit right format wrong");

	property p_fmt_20l;
		fmtCode == 2'h2
			|-> wordLen20 && dacJustify == JUST_LEFT && adcJustify == JUST_LEFT;
	endproperty
	a_fmt_20l: assert property (p_fmt_20l) else $error("20-bit left format wrong");

	// hard mute only ever at the gain floor
	property p_left_tie_floor;
		leftTieCommonMode |-> leftRecordGain == `ACR_GAIN_MIN;
	endproperty
	a_left_tie_floor: assert property (p_left_tie_floor) else $error("left tied above floor");

	property p_right_tie_floor;
		rightTieCommonMode |-> rightRecordGain == `ACR_GAIN_MIN;
	endproperty
	a_right_tie_floor: assert property (p_right_tie_floor) else $error("right tied above floor");

	c_write_path: cover property (regWrite && regAddr == `ACR_ADDR_PATH);
	c_left_unmuted: cover property ($fell(leftTieCommonMode));
	c_right_unmuted: cover property ($fell(rightTieCommonMode));
endmodule // acr_record_regs
`default_nettype wire

// ===== acr_host_model.sv
// host model driving the register strobe port of the record-path registers
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"
module acr_host_model
	import acr_pkg::*;
(
	// clock
	input  wire logic                   clk,
	// register strobe port
	output var  logic                   regWrite,
	output var  logic                   regRead,
	output var  logic [`ACR_ADDR_W-1:0] regAddr,
	output var  logic [15:0]            regWdata,
	input  wire logic [15:0]            regRdata,
	input  wire logic                   regRdValid
);
	// idle port at time zero
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = '0;
		regWdata = 16'h0000;
	end

	// one-cycle write; rate code kept legal unless raw is asked for
	task automatic wr(input logic [5:0] a, input logic [15:0] d, input bit raw = 1'b0);
		logic [15:0] w;
		w = d;
		if (!raw && a == `ACR_ADDR_PATH && w[5:2] > `ACR_RATE_MAX) w[5:2] = `ACR_RATE_MAX;
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= w;
		@(posedge clk);
		regWrite <= 1'b0;
		regWdata <= ~w; // no stale data once released
	endtask

	// one-cycle read; data taken with the valid pulse
	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		d = 16'hxxxx;
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			#1;
			if (regRdValid === 1'b1) begin
				d = regRdata;
				break;
			end
			@(posedge clk);
		end
	endtask
endmodule // acr_host_model
`default_nettype wire

// ===== audio_codec_input_and_adc_gain_regs_tb.sv
// self-checking bench for the record-path configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"
module audio_codec_input_and_adc_gain_regs_tb
	import acr_pkg::*;
;
	logic clk, rst_n, regWrite, regRead, regRdValid, sampleRateValid, wordLen20;
	logic [5:0] regAddr;
	logic [15:0] regWdata, regRdata, w, d;
	logic [1:0] leftInputSelect, rightInputSelect;
	logic [3:0] sampleRateCode;
	logic [6:0] leftRecordGain, rightRecordGain, prevL, prevR;
	logic leftTieCommonMode, rightTieCommonMode, leftRamping, rightRamping, prevTl, prevTr;
	acr_mic_e micPreampGain;
	acr_mclk_e mclkRatio;
	acr_just_e dacJustify, adcJustify;
	int seed = 85;
	int fails = 0;
	int checksDone = 0;

	// design and host model
	acr_record_regs DUT (.clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
		.leftInputSelect(leftInputSelect), .rightInputSelect(rightInputSelect),
		.micPreampGain(micPreampGain), .mclkRatio(mclkRatio), .sampleRateCode(sampleRateCode),
		.sampleRateValid(sampleRateValid), .wordLen20(wordLen20), .dacJustify(dacJustify),
		.adcJustify(adcJustify), .leftRecordGain(leftRecordGain),
		.leftTieCommonMode(leftTieCommonMode), .leftRamping(leftRamping),
		.rightRecordGain(rightRecordGain), .rightTieCommonMode(rightTieCommonMode),
		.rightRamping(rightRamping));
	acr_host_model host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid));

	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// expected decodes of the path word
	function automatic acr_mic_e expMic(input logic [1:0] c);
		return c == 2'h3 ? MIC_GAIN_12DB : c == 2'h2 ? MIC_GAIN_6DB : MIC_GAIN_0DB;
	endfunction
	function automatic acr_mclk_e expMclk(input logic [1:0] c);
		return c == 2'h1 ? MCLK_384FS : c == 2'h2 ? MCLK_512FS : MCLK_256FS;
	endfunction
	function automatic acr_just_e expDac(input logic [1:0] c);
		return c == 2'h3 ? JUST_I2S : c == 2'h2 ? JUST_LEFT : JUST_RIGHT;
	endfunction

	// read back path word and compare every decoded field
	task automatic checkPath(input logic [15:0] e);
		host.rd(`ACR_ADDR_PATH, d);
		check("path word", d, e);
		check("left select", 16'(leftInputSelect), 16'(e[13:12]));
		check("right select", 16'(rightInputSelect), 16'(e[11:10]));
		check("mic gain", 16'(micPreampGain), 16'(expMic(e[9:8])));
		check("mclk ratio", 16'(mclkRatio), 16'(expMclk(e[7:6])));
		check("rate code", 16'(sampleRateCode), 16'(e[5:2]));
		check("rate valid", 16'(sampleRateValid), 16'(e[5:2] <= 4'h8));
		check("word length", 16'(wordLen20), 16'(e[1:0] != 2'h0));
		check("dac format", 16'(dacJustify), 16'(expDac(e[1:0])));
		check("adc format", 16'(adcJustify), 16'(e[1:0] == 2'h3 ? JUST_I2S : JUST_LEFT));
	endtask

	// write gain word, wait out the soft-step, compare end state
	task automatic settle(input logic [15:0] g, input logic [6:0] el, er, input logic tl, tr);
		int n;
		host.wr(`ACR_ADDR_GAIN, g);
		repeat (2) @(posedge clk);
		#1;
		for (n = 0; n < 14000 && (leftRamping !== 1'b0 || rightRamping !== 1'b0); n++) begin
			@(posedge clk);
			#1;
		end
		check("ramp finished", 16'(n < 14000), 16'h1);
		check("left gain", 16'(leftRecordGain), 16'(el));
		check("left tie", 16'(leftTieCommonMode), 16'(tl));
		check("right gain", 16'(rightRecordGain), 16'(er));
		check("right tie", 16'(rightTieCommonMode), 16'(tr));
		host.rd(`ACR_ADDR_GAIN, d);
		check("gain word", d, g);
		host.rd(`ACR_ADDR_STATUS, d);
		check("status word", d, {tl, el, tr, er});
	endtask

	// first edge after a reset release: every reset value
	task automatic checkReset();
		@(posedge clk);
		#1;
		check("reset left gain", 16'(leftRecordGain), 16'h07);
		check("reset left tie", 16'(leftTieCommonMode), 16'h1);
		check("reset right gain", 16'(rightRecordGain), 16'h07);
		check("reset right tie", 16'(rightTieCommonMode), 16'h1);
		check("reset read data", regRdata, 16'h0000);
		check("reset read valid", 16'(regRdValid), 16'h0);
		checkPath(16'hc003);
		host.rd(`ACR_ADDR_GAIN, d);
		check("reset gain word", d, 16'hd7d7);
	endtask

	// every applied gain move is one code; tie changes only at the floor
	always @(posedge clk) begin
		if (rst_n === 1'b1 && leftRecordGain !== prevL)
			check("left step", 16'((leftRecordGain - prevL) == 7'h01 || (prevL - leftRecordGain) == 7'h01), 16'h1);
		if (rst_n === 1'b1 && rightRecordGain !== prevR)
			check("right step", 16'((rightRecordGain - prevR) == 7'h01 || (prevR - rightRecordGain) == 7'h01), 16'h1);
		if (rst_n === 1'b1 && leftTieCommonMode !== prevTl)
			check("left tie at floor", 16'(leftRecordGain), 16'h07);
		if (rst_n === 1'b1 && rightTieCommonMode !== prevTr)
			check("right tie at floor", 16'(rightRecordGain), 16'h07);
		prevL <= leftRecordGain;
		prevR <= rightRecordGain;
		prevTl <= leftTieCommonMode;
		prevTr <= rightTieCommonMode;
	end

	// watchdog
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		checkReset();
		// every two-bit code and every legal rate code
		for (int i = 0; i < 9; i++) begin
			w = {2'(i), 2'(i), 2'(i), 2'(i), 2'(i), 4'(i), 2'(i)};
			host.wr(`ACR_ADDR_PATH, w);
			checkPath(w);
		end
		repeat (12) begin
			w = 16'($random(seed));
			w[5:2] = w[5:2] % 4'h9;
			host.wr(`ACR_ADDR_PATH, w);
			checkPath(w);
		end
		// illegal rate stored but flagged; unmapped places refused
		host.wr(`ACR_ADDR_PATH, 16'hc03f, 1'b1);
		checkPath(16'hc03f);
		host.wr(6'h3f, 16'h1234);
		host.wr(`ACR_ADDR_STATUS, 16'hffff);
		checkPath(16'hc03f);
		host.rd(6'h3f, d);
		check("unmapped read", d, 16'h0000);
		// soft-stepped gain and mute sequences
		settle(16'h0989, 7'h09, 7'h07, 1'b0, 1'b1);
		settle(16'h0309, 7'h07, 7'h09, 1'b1, 1'b0);
		settle(16'h0b89, 7'h0b, 7'h07, 1'b0, 1'b1);
		settle(16'h8b89, 7'h07, 7'h07, 1'b1, 1'b1);
		settle(16'h0b89, 7'h0b, 7'h07, 1'b0, 1'b1);
		// new target mid-ramp redirects the stepper
		host.wr(`ACR_ADDR_GAIN, 16'h1189);
		repeat (4100) @(posedge clk);
		#1;
		check("redirect midway", 16'(leftRecordGain > 7'h0b && leftRecordGain < 7'h11), 16'h1);
		settle(16'h0989, 7'h09, 7'h07, 1'b0, 1'b1);
		// reset in mid-run restores every default
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		checkReset();
		tally_and_finish();
	end
endmodule // audio_codec_input_and_adc_gain_regs_tb
`default_nettype wire
